// File: hdl/udl_device.sv
// device end: write lock, irq pulse width and line test registers
// assumes host bus and user inputs are on sys_clk
`timescale 1ns/1ps
`include "udl_map.svh"
module udl_device import udl_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// register bus
	udl_bus_if.device bus,
	// usb state
	input wire logic suspend,
	input wire logic busReset,
	input wire logic hsInToken,
	// fifo write gate
	input wire logic fifoWrReq,
	output logic fifoWrGrant,
	// interrupt
	input wire logic irqEvent,
	input wire logic irqLevel,
	input wire logic irqPulseMode,
	output logic irqOut,
	// speed control
	output logic forceHighSpeed,
	output logic forceFullSpeed,
	output logic chirpEnable,
	// line test drive
	output logic lineDp,
	output logic lineDm,
	output logic lineOe,
	output logic quietNakMode,
	output logic sendNak,
	// status
	output logic writeLocked
);
	udl_dev_t s;
	udl_dev_t next_s;
	logic wrHit;
	logic wrAllowed;
	logic keyOk;
	logic suspendEntry;
	logic prbsBit;

	// ==============================
	// helpers
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [15:0] val,
		input logic [1:0] be
	);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = val[7:0];
		end
		if (be[1]) begin
			r[15:8] = val[15:8];
		end
		return r;
	endfunction : merge16

	function automatic logic [15:0] readMux(
		input logic [`UDL_ADDR_W-1:0] a,
		input udl_dev_t st
	);
		logic [15:0] r;
		r = 16'h0000;
		unique case (a)
			`UDL_OFS_PULSE: begin
				r = st.pulseCount;
			end
			`UDL_OFS_TEST: begin
				r = {8'h00, st.testCtrl};
			end
			default: begin
				r = 16'h0000;
			end
		endcase
		return r;
	endfunction : readMux

	// ==============================
	// write decode and lock
	always_comb begin
		next_s = s;
		wrHit = bus.req & bus.write;
		keyOk = wrHit
			& (bus.addr == `UDL_OFS_UNLOCK)
			& (bus.byteEn == 2'b11)
			& (bus.wdata == `UDL_UNLOCK_KEY);
		wrAllowed = wrHit & ~s.locked;
		suspendEntry = suspend & ~s.prevSuspend;
		next_s.prevSuspend = suspend;
		if (keyOk) begin
			next_s.locked = 1'b0;
		end
		if (suspendEntry) begin
			next_s.locked = 1'b1;
		end

		// ==============================
		// register writes
		if (wrAllowed && bus.addr == `UDL_OFS_PULSE) begin
			next_s.pulseCount = merge16(s.pulseCount, bus.wdata, bus.byteEn);
		end
		if (wrAllowed && bus.addr == `UDL_OFS_TEST && bus.byteEn[0]) begin
			next_s.testCtrl = bus.wdata[7:0];
		end
		if (busReset) begin
			next_s.testCtrl = s.testCtrl & `UDL_TEST_KEEP_MASK;
		end

		// ==============================
		// bus answer, reads ignore the lock
		next_s.ack = bus.req;
		next_s.rdata = 16'h0000;
		if (bus.req && !bus.write) begin
			next_s.rdata = readMux(bus.addr, s);
		end

		// ==============================
		// line test pattern source
		prbsBit = s.pseudo_random_pattern[14] ^ s.pseudo_random_pattern[13];
		if (s.testCtrl[`UDL_BIT_PATTERN]) begin
			next_s.pseudo_random_pattern = {s.pseudo_random_pattern[13:0], prbsBit};
		end else begin
			next_s.pseudo_random_pattern = `UDL_PSEUDO_RANDOM_PATTERN_SEED;
		end

		// ==============================
		// line drive
		next_s.lineOe = 1'b1;
		if (s.testCtrl[`UDL_BIT_PATTERN]) begin
			next_s.dp = prbsBit;
			next_s.dm = ~prbsBit;
		end else if (s.testCtrl[`UDL_BIT_K]) begin
			next_s.dp = 1'b0;
			next_s.dm = 1'b1;
		end else if (s.testCtrl[`UDL_BIT_J]) begin
			next_s.dp = 1'b1;
			next_s.dm = 1'b0;
		end else if (s.testCtrl[`UDL_BIT_QUIET]) begin
			next_s.dp = 1'b0;
			next_s.dm = 1'b0;
		end else begin
			next_s.dp = 1'b0;
			next_s.dm = 1'b0;
			next_s.lineOe = 1'b0;
		end

		// ==============================
		// quiet mode answers only hs in tokens with nak
		next_s.sendNak = s.testCtrl[`UDL_BIT_QUIET] & hsInToken;
	end

	// ==============================
	// state register
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s <= '0;
			s.pulseCount <= `UDL_PULSE_RESET;
			s.testCtrl <= `UDL_TEST_RESET;
			s.pseudo_random_pattern <= `UDL_PSEUDO_RANDOM_PATTERN_SEED;
		end else begin
			s <= next_s;
		end
	end

	// ==============================
	// interrupt shaping
	udl_irq_pulse u_irq (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.pulseMode(irqPulseMode),
		.pulseCount(s.pulseCount),
		.trigger(irqEvent),
		.irqLevel(irqLevel),
		.irqOut(irqOut)
	);

	// ==============================
	// outputs
	assign bus.ack = s.ack;
	assign bus.rdata = s.rdata;
	assign fifoWrGrant = fifoWrReq & ~s.locked;
	assign forceHighSpeed = s.testCtrl[`UDL_BIT_FORCE_HS];
	assign forceFullSpeed = s.testCtrl[`UDL_BIT_FORCE_FS];
	assign chirpEnable = ~(forceHighSpeed | forceFullSpeed);
	assign lineDp = s.dp;
	assign lineDm = s.dm;
	assign lineOe = s.lineOe;
	assign quietNakMode = s.testCtrl[`UDL_BIT_QUIET];
	assign sendNak = s.sendNak;
	assign writeLocked = s.locked;
endmodule : udl_device

// File: hdl/udl_map.svh
// constants of the unlock, irq pulse and line test register bank
// assumes a 16-bit parallel register bus with byte enables
// Behaviour
// - suspend entry locks all register writes
// - after resume host writes key first
// - full 16-bit key write AA37 unlocks writes
// - 16-bit register sets irq pulse width
// - pulse lasts count times 3.33 ns unit
// - pulse width resets to 1Eh
// - force high speed disables chirp detection
// - force full speed disables chirp detection
// - pattern bit toggles lines pseudo-randomly
// - K bit drives K state
// - J bit drives J state
// - quiet bit idles lines, NAKs HS IN
// - host sets at most one line-test bit
// - host never sets both force bits
// - bus reset keeps force bits, clears others
// - host writes reserved bits as zero
`ifndef UDL_MAP_SVH
`define UDL_MAP_SVH
// ==============================
// device register map
`define UDL_ADDR_W 10
`define UDL_OFS_UNLOCK 10'h27C
`define UDL_OFS_PULSE 10'h280
`define UDL_OFS_TEST 10'h284
`define UDL_UNLOCK_KEY 16'hAA37
`define UDL_PULSE_RESET 16'h001E
`define UDL_TEST_RESET 8'h00
// ==============================
// line test fields
`define UDL_BIT_FORCE_HS 7
`define UDL_BIT_FORCE_FS 4
`define UDL_BIT_PATTERN 3
`define UDL_BIT_K 2
`define UDL_BIT_J 1
`define UDL_BIT_QUIET 0
`define UDL_TEST_KEEP_MASK 8'h90
`define UDL_TEST_RSVD_MASK 8'h60
`define UDL_PSEUDO_RANDOM_PATTERN_SEED 15'h7FFF
// ==============================
// timing
`define UDL_PULSE_UNIT_PS 32'h0000_0D02
`define UDL_CLK_PERIOD_PS 32'h0000_1F40
// ==============================
// host controller apb map
`define UDL_APB_ORDER 12'h000
`define UDL_APB_WDATA 12'h004
`define UDL_APB_STATUS 12'h008
`define UDL_APB_RDATA 12'h00C
`define UDL_ORD_WRITE 24
`endif

// File: hdl/udl_pkg.sv
// types shared by both ends of the register bus
// assumes udl_map.svh for the widths
`include "udl_map.svh"
package udl_pkg;
	// ==============================
	// host controller sequence
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_UNLK = 2'b01,
		H_WAIT = 2'b10
	} udl_hstate_t;
	// ==============================
	// state records
	typedef struct packed {
		logic locked;
		logic prevSuspend;
		logic [15:0] pulseCount;
		logic [7:0] testCtrl;
		logic [14:0] pseudo_random_pattern;
		logic ack;
		logic [15:0] rdata;
		logic sendNak;
		logic dp;
		logic dm;
		logic lineOe;
	} udl_dev_t;
	typedef struct packed {
		logic active;
		logic [31:0] remain;
		logic irqOut;
	} udl_pulse_t;
	typedef struct packed {
		udl_hstate_t st;
		logic [`UDL_ADDR_W-1:0] addr;
		logic [1:0] byteEn;
		logic write;
		logic [15:0] wdata;
		logic [15:0] readData;
		logic needUnlock;
		logic refused;
		logic req;
		logic reqWrite;
		logic [`UDL_ADDR_W-1:0] reqAddr;
		logic [1:0] reqBe;
		logic [15:0] reqData;
	} udl_host_t;
endpackage : udl_pkg

// File: hdl/udl_bus_if.sv
// parallel register bus between host controller and device
// assumes both ends run on the same sys_clk
`timescale 1ns/1ps
interface udl_bus_if #(parameter int AW = 10);
	logic req;
	logic write;
	logic [AW-1:0] addr;
	logic [1:0] byteEn;
	logic [15:0] wdata;
	logic ack;
	logic [15:0] rdata;
	modport host (output req, write, addr, byteEn, wdata, input ack, rdata);
	modport device (input req, write, addr, byteEn, wdata, output ack, rdata);
endinterface : udl_bus_if

// File: hdl/udl_irq_pulse.sv
// interrupt output shaper: level mode or programmed pulse width
// assumes trigger is a one-cycle pulse on sys_clk
`timescale 1ns/1ps
`include "udl_map.svh"
module udl_irq_pulse import udl_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// control
	input wire logic pulseMode,
	input wire logic [15:0] pulseCount,
	input wire logic trigger,
	input wire logic irqLevel,
	// output
	output logic irqOut
);
	udl_pulse_t s;
	udl_pulse_t next_s;
	logic [31:0] target;

	// ==============================
	// pulse timing
	always_comb begin
		next_s = s;
		target = 32'(pulseCount) * `UDL_PULSE_UNIT_PS;
		if (trigger) begin
			next_s.active = 1'b1;
			next_s.remain = target;
		end else if (s.active) begin
			if (s.remain > `UDL_CLK_PERIOD_PS) begin
				next_s.remain = s.remain - `UDL_CLK_PERIOD_PS;
			end else begin
				next_s.active = 1'b0;
			end
		end
		next_s.irqOut = pulseMode ? next_s.active : irqLevel;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign irqOut = s.irqOut;
endmodule : udl_irq_pulse

// File: hdl/udl_host.sv
// host end: apb-programmed controller issuing device bus cycles
// assumes apb and device bus share sys_clk
`timescale 1ns/1ps
`include "udl_map.svh"
module udl_host import udl_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device events
	input wire logic deviceResumed,
	// device bus
	udl_bus_if.host bus
);
	udl_host_t s;
	udl_host_t next_s;
	logic apbWr;
	logic [`UDL_ADDR_W-1:0] oAddr;
	logic [1:0] oBe;
	logic oWrite;
	logic [7:0] tv;
	logic bad;
	logic toUnlock;

	function automatic logic multiHot(input logic [3:0] v);
		return (v & (v - 4'h1)) != 4'h0;
	endfunction : multiHot

	// ==============================
	// order handling
	always_comb begin
		next_s = s;
		next_s.req = 1'b0;
		apbWr = psel & penable & pwrite;
		oAddr = pwdata[`UDL_ADDR_W-1:0];
		oBe = pwdata[17:16];
		oWrite = pwdata[`UDL_ORD_WRITE];
		tv = s.wdata[7:0];
		bad = oWrite && oAddr == `UDL_OFS_TEST
			&& (multiHot(tv[3:0])
			|| (tv[`UDL_BIT_FORCE_HS] && tv[`UDL_BIT_FORCE_FS]));
		toUnlock = oWrite && oAddr == `UDL_OFS_UNLOCK;
		if (apbWr && paddr == `UDL_APB_WDATA) begin
			next_s.wdata = pwdata[15:0];
		end
		unique case (s.st)
			H_IDLE: begin
				if (apbWr && paddr == `UDL_APB_ORDER) begin
					next_s.refused = bad;
					if (!bad) begin
						next_s.addr = oAddr;
						next_s.byteEn = oBe;
						next_s.write = oWrite;
						next_s.req = 1'b1;
						next_s.reqWrite = oWrite;
						next_s.reqAddr = oAddr;
						next_s.reqBe = oBe;
						next_s.reqData = s.wdata;
						if (oAddr == `UDL_OFS_TEST) begin
							next_s.reqData = s.wdata & ~16'(`UDL_TEST_RSVD_MASK);
						end
						next_s.st = H_WAIT;
						if (s.needUnlock && oWrite && !toUnlock) begin
							next_s.reqWrite = 1'b1;
							next_s.reqAddr = `UDL_OFS_UNLOCK;
							next_s.reqBe = 2'b11;
							next_s.reqData = `UDL_UNLOCK_KEY;
							next_s.st = H_UNLK;
						end
					end
				end
			end
			H_UNLK: begin
				if (bus.ack) begin
					next_s.needUnlock = 1'b0;
					next_s.req = 1'b1;
					next_s.reqWrite = s.write;
					next_s.reqAddr = s.addr;
					next_s.reqBe = s.byteEn;
					next_s.reqData = s.wdata;
					if (s.addr == `UDL_OFS_TEST) begin
						next_s.reqData = s.wdata & ~16'(`UDL_TEST_RSVD_MASK);
					end
					next_s.st = H_WAIT;
				end
			end
			H_WAIT: begin
				if (bus.ack) begin
					if (!s.write) begin
						next_s.readData = bus.rdata;
					end
					if (s.write && s.addr == `UDL_OFS_UNLOCK) begin
						next_s.needUnlock = 1'b0;
					end
					next_s.st = H_IDLE;
				end
			end
			default: begin
				next_s.st = H_IDLE;
			end
		endcase
		if (deviceResumed) begin
			next_s.needUnlock = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s <= '0;
			s.st <= H_IDLE;
		end else begin
			s <= next_s;
		end
	end

	// ==============================
	// apb read and outputs
	always_comb begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite) begin
			unique case (paddr)
				`UDL_APB_WDATA: prdata = {16'h0000, s.wdata};
				`UDL_APB_STATUS: prdata = {29'h0, s.refused, s.needUnlock, s.st != H_IDLE};
				`UDL_APB_RDATA: prdata = {16'h0000, s.readData};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign bus.req = s.req;
	assign bus.write = s.reqWrite;
	assign bus.addr = s.reqAddr;
	assign bus.byteEn = s.reqBe;
	assign bus.wdata = s.reqData;
endmodule : udl_host

// File: verif/udl_asserts.sv
// checker of the device bus and the device status outputs
// assumes one sys_clk domain, instanced in tb_top beside the bus interface
`timescale 1ns/1ps
`include "udl_map.svh"
module udl_asserts (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// device bus
	input wire logic req,
	input wire logic write,
	input wire logic [9:0] addr,
	input wire logic [1:0] byteEn,
	input wire logic [15:0] wdata,
	input wire logic ack,
	input wire logic [15:0] rdata,
	// device side
	input wire logic suspend,
	input wire logic busReset,
	input wire logic hsInToken,
	input wire logic writeLocked,
	input wire logic quietNakMode,
	input wire logic sendNak,
	input wire logic forceHighSpeed,
	input wire logic forceFullSpeed,
	input wire logic chirpEnable
);
	// ==============================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic keyWr;
	assign keyWr = req && write && addr == 10'h27C && byteEn == 2'h3 && wdata == 16'hAA37;
	AST_BUS_ACK: assert property (req |=> ack) else $error("no ack");
	AST_ACK_CAUSE: assert property (ack |-> $past(req)) else $error("stray ack");
	AST_LOCK_SET: assert property ($rose(suspend) |=> writeLocked) else $error("no lock");
	AST_LOCK_HOLD: assert property (writeLocked && !keyWr |=> writeLocked)
		else $error("lock lost");
	AST_UNLOCK: assert property (keyWr && !suspend |=> !writeLocked) else $error("no unlock");
	AST_KEY_RD: assert property (req && !write && addr == 10'h27C |=> rdata == 16'h0000)
		else $error("key readable");
	AST_CHIRP: assert property (chirpEnable == !(forceHighSpeed || forceFullSpeed))
		else $error("chirp wrong");
	AST_NAK: assert property (hsInToken && quietNakMode |=> sendNak) else $error("no nak");
	AST_NAK_CAUSE: assert property (sendNak |-> $past(hsInToken) && $past(quietNakMode))
		else $error("stray nak");
	AST_BUS_RST: assert property (busReset && !$past(req && write) |=>
		!quietNakMode && $stable({forceHighSpeed, forceFullSpeed})) else $error("bus reset");
endmodule : udl_asserts

// File: verif/tb_top.sv
// bench for the unlock, irq pulse width and line test registers
// assumes udl_pkg, udl_bus_if, udl_host, udl_device, udl_asserts compiled first
`timescale 1ns/1ps
`include "udl_map.svh"
module tb_top;
	// ==============================
	// signals and model
	localparam logic R = 1'h0;
	localparam logic W = 1'h1;
	localparam logic [1:0] B = 2'h3;
	logic sys_clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, st;
	logic deviceResumed = 1'h0, suspend = 1'h0, busReset = 1'h0, hsInToken = 1'h0;
	logic fifoWrReq = 1'h0, irqEvent = 1'h0, irqLevel = 1'h0, irqPulseMode = 1'h0;
	logic fifoWrGrant, irqOut, forceHighSpeed, forceFullSpeed, chirpEnable, pready, pslverr;
	logic lineDp, lineDm, lineOe, quietNakMode, sendNak, writeLocked;
	int num_errors = 0, n_tests = 0, pw = 32'h1E, tm = 0, lk = 0, n, i, c;
	udl_bus_if #(.AW(10)) bi ();
	always #4 sys_clk = ~sys_clk;
	udl_host udl_host_i (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .deviceResumed, .bus(bi));
	udl_device udl_device_i (.sys_clk, .resetn, .bus(bi), .suspend, .busReset, .hsInToken,
		.fifoWrReq, .fifoWrGrant, .irqEvent, .irqLevel, .irqPulseMode, .irqOut,
		.forceHighSpeed, .forceFullSpeed, .chirpEnable, .lineDp, .lineDm, .lineOe,
		.quietNakMode, .sendNak, .writeLocked);
	udl_asserts udl_asserts_i (.sys_clk, .resetn, .req(bi.req), .write(bi.write),
		.addr(bi.addr), .byteEn(bi.byteEn), .wdata(bi.wdata), .ack(bi.ack), .rdata(bi.rdata),
		.suspend, .busReset, .hsInToken, .writeLocked, .quietNakMode, .sendNak,
		.forceHighSpeed, .forceFullSpeed, .chirpEnable);
	// ==============================
	// tasks
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic rdy;
		@(posedge sys_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		rdy = 1'h0;
		while (rdy !== 1'h1) begin
			// settled values just before the edge that samples them
			@(negedge sys_clk);
			rdy = pready;
			rd = prdata;
			@(posedge sys_clk);
		end
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task op(input logic w, input logic [9:0] a, input logic [1:0] be, input logic [15:0] d);
		apb(W, 12'h004, {16'h0000, d});
		apb(W, 12'h000, {7'h00, w, 6'h00, be, 6'h00, a});
		st = 32'h1;
		while (st[0] !== 1'h0) begin
			apb(R, 12'h008, 32'h0);
			st = rd;
		end
		if (w && a == 10'h27C && be == B && d == 16'hAA37) lk = 0;
		else if (w && lk == 0 && a == 10'h280) begin
			if (be[0]) pw[7:0] = d[7:0];
			if (be[1]) pw[15:8] = d[15:8];
		end else if (w && lk == 0 && a == 10'h284 && be[0]) tm = d[7:0] & 8'h9F;
		if (!w) begin
			apb(R, 12'h00C, 32'h0);
			chk("read", a == 10'h280 ? pw : a == 10'h284 ? tm : 0, rd);
		end
	endtask : op
	task report_and_stop;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop
	// ==============================
	// watchdog
	initial begin
		#200000;
		num_errors++;
		report_and_stop();
	end
	// ==============================
	// tests
	initial begin
		void'($urandom(32'hBE7084B8));
		repeat (8) @(posedge sys_clk);
		resetn <= 1'h1;
		op(R, 10'h280, B, 16'h0000);
		op(R, 10'h284, B, 16'h0000);
		op(R, 10'h27C, B, 16'h0000);
		chk("chirp", 1, chirpEnable);
		for (i = 0; i < 4; i++) begin
			op(W, 10'h280, 2'($urandom_range(1, 3)), 16'($urandom));
			op(R, 10'h280, B, 16'h0000);
		end
		for (i = 0; i < 4; i++) begin
			op(W, 10'h284, B, 16'h0001 << i);
			op(R, 10'h284, B, 16'h0000);
			@(negedge sys_clk) chk("oe", 1, lineOe);
			if (i == 3) begin
				c = 0;
				repeat (40) begin
					@(negedge sys_clk);
					c += lineDp;
					chk("dm", !lineDp, lineDm);
				end
				chk("toggle", 1, c > 0 && c < 40);
			end else chk("dpdm", i == 0 ? 0 : i == 1 ? 2 : 1, {lineDp, lineDm});
			@(posedge sys_clk) hsInToken <= 1'h1;
			@(posedge sys_clk) hsInToken <= 1'h0;
			@(negedge sys_clk) chk("nak", i == 0, sendNak);
		end
		op(W, 10'h284, B, 16'h0081);
		chk("force", 4, {forceHighSpeed, forceFullSpeed, chirpEnable});
		@(posedge sys_clk) busReset <= 1'h1;
		@(posedge sys_clk) busReset <= 1'h0;
		tm = tm & 8'h90;
		op(R, 10'h284, B, 16'h0000);
		chk("oe", 0, lineOe);
		op(W, 10'h284, B, 16'h0072);
		chk("force", 2, {forceHighSpeed, forceFullSpeed, chirpEnable});
		op(R, 10'h284, B, 16'h0000);
		for (i = 0; i < 2; i++) begin
			apb(W, 12'h004, i ? 32'h90 : 32'h3);
			apb(W, 12'h000, 32'h0103_0284);
			apb(R, 12'h008, 32'h0);
			chk("refused", 1, rd[2]);
		end
		op(R, 10'h284, B, 16'h0000);
		fifoWrReq <= 1'h1;
		@(posedge sys_clk) suspend <= 1'h1;
		lk = 1;
		repeat (3) @(posedge sys_clk);
		chk("lock", 1, writeLocked);
		chk("grant", 0, fifoWrGrant);
		suspend <= 1'h0;
		op(W, 10'h280, B, 16'h1234);
		op(R, 10'h280, B, 16'h0000);
		op(W, 10'h27C, 2'h1, 16'hAA37);
		op(W, 10'h27C, B, 16'hAA36);
		op(W, 10'h284, B, 16'h0004);
		op(R, 10'h284, B, 16'h0000);
		op(W, 10'h27C, B, 16'hAA37);
		chk("grant", 1, fifoWrGrant);
		chk("lock", 0, writeLocked);
		@(posedge sys_clk) suspend <= 1'h1;
		@(posedge sys_clk) suspend <= 1'h0;
		deviceResumed <= 1'h1;
		@(posedge sys_clk) deviceResumed <= 1'h0;
		chk("lock", 1, writeLocked);
		lk = 0;
		apb(R, 12'h008, 32'h0);
		chk("resume", 1, rd[1]);
		op(W, 10'h280, B, 16'($urandom_range(0, 150)));
		op(R, 10'h280, B, 16'h0000);
		irqPulseMode <= 1'h1;
		for (i = 0; i < 2; i++) begin
			if (i) op(W, 10'h280, B, 16'h001E);
			@(posedge sys_clk) irqEvent <= 1'h1;
			@(posedge sys_clk) irqEvent <= 1'h0;
			n = 0;
			repeat (100) @(negedge sys_clk) n += irqOut;
			c = (pw * `UDL_PULSE_UNIT_PS + `UDL_CLK_PERIOD_PS - 1) / `UDL_CLK_PERIOD_PS;
			chk("width", c < 1 ? 1 : c, n);
		end
		@(posedge sys_clk);
		irqPulseMode <= 1'h0;
		irqLevel <= 1'h1;
		@(posedge sys_clk);
		@(negedge sys_clk) chk("level", 1, irqOut);
		chk("pslverr", 0, pslverr);
		report_and_stop();
	end
endmodule : tb_top
